// ===== logic/drum_pkg.sv
/*
 * shared constants and carrier types of the masked event drum sequencer.
 * assumes a single 125 mhz clock and a plain strobe register port.
 */
package drum_pkg;

	// ****************************************
	// sizes and timing
	// ****************************************
	localparam int STEPS = 16;
	localparam int CLOCK_PERIOD_NS = 8;
	localparam int TIMEBASE_UNIT_NS = 10_000_000;
	localparam int TICK_CYCLES = TIMEBASE_UNIT_NS / CLOCK_PERIOD_NS;
	localparam logic [15:0] MAX_COUNTS = 16'h270f;
	localparam logic [15:0] MAX_TIMEBASE = 16'h270f;
	localparam logic [7:0] MAX_CTR_BASE = 8'hae;
	localparam logic [4:0] FIRST_STEP = 5'h01;
	localparam logic [4:0] LAST_STEP = 5'h10;

	// ****************************************
	// register word offsets
	// ****************************************
	localparam logic [7:0] CONTROL_OFS = 8'h00;
	localparam logic [7:0] TIMEBASE_OFS = 8'h01;
	localparam logic [7:0] CTR_BASE_OFS = 8'h02;
	localparam logic [7:0] EVENT_ASSIGN_OFS = 8'h03;
	localparam logic [7:0] FLAGS_OFS = 8'h04;
	localparam logic [7:0] WORD_DEST_OFS = 8'h05;
	localparam logic [7:0] STEP_COUNT_OFS = 8'h08;
	localparam logic [7:0] TIMER_VALUE_OFS = 8'h09;
	localparam logic [7:0] PRESET_STEP_OFS = 8'h0a;
	localparam logic [7:0] CURRENT_STEP_OFS = 8'h0b;

	// ****************************************
	// field positions and reset values
	// ****************************************
	localparam int RUN_MODE_BIT = 0;
	localparam int WORD_MODE_BIT = 1;
	localparam int COMPLETE_BIT = 0;
	localparam logic [4:0] PRESET_RESET = 5'h01;
	localparam logic [15:0] TIMEBASE_RESET = 16'h0001;
	localparam logic [7:0] CTR_BASE_RESET = 8'h00;

	// per-step table field, equal to address bits [5:4] of the table window
	typedef enum logic [1:0] {
		FIELD_NONE = 2'b00,
		FIELD_MASK = 2'b01,
		FIELD_PATTERN = 2'b10,
		FIELD_COUNTS = 2'b11
	} field_t;

	typedef struct packed {
		logic [15:0] mask;
		logic [15:0] pattern;
		logic [15:0] counts;
	} step_entry_t;

endpackage

// ===== logic/drum_step_table.sv
/*
 * sixteen-entry per-step table: mask word, output pattern, counts per step.
 * assumes one write or one bus read per cycle; both read ports are registered.
 */
module drum_step_table (
	// clock and reset
	input wire logic clock_in,
	input wire logic rst_in,
	// bus side
	input wire logic wr_en_in,
	input wire drum_pkg::field_t field_in,
	input wire logic [3:0] index_in,
	input wire logic [15:0] wr_data_in,
	output logic [15:0] bus_rdata_out,
	// sequencer side
	input wire logic [3:0] step_index_in,
	output drum_pkg::step_entry_t step_entry_out
);

	drum_pkg::step_entry_t table_q [drum_pkg::STEPS];

	// ****************************************
	// storage, one entry per step
	// ****************************************
	genvar i;
	generate
		for (i = 0; i < drum_pkg::STEPS; i++) begin : g_entry
			always_ff @(posedge clock_in) begin
				if (rst_in) begin
					table_q[i] <= '0;
				end else if (wr_en_in && index_in == 4'(i)) begin
					unique case (field_in)
						drum_pkg::FIELD_MASK: table_q[i].mask <= wr_data_in;
						drum_pkg::FIELD_PATTERN: table_q[i].pattern <= wr_data_in;
						drum_pkg::FIELD_COUNTS: table_q[i].counts <= wr_data_in;
						drum_pkg::FIELD_NONE: table_q[i] <= table_q[i];
					endcase
				end
			end
		end
	endgenerate

	// ****************************************
	// registered read ports
	// ****************************************
	always_ff @(posedge clock_in) begin
		if (rst_in) begin
			bus_rdata_out <= '0;
			step_entry_out <= '0;
		end else begin
			unique case (field_in)
				drum_pkg::FIELD_MASK: bus_rdata_out <= table_q[index_in].mask;
				drum_pkg::FIELD_PATTERN: bus_rdata_out <= table_q[index_in].pattern;
				drum_pkg::FIELD_COUNTS: bus_rdata_out <= table_q[index_in].counts;
				drum_pkg::FIELD_NONE: bus_rdata_out <= '0;
			endcase
			step_entry_out <= table_q[step_index_in];
		end
	end

endmodule

// ===== logic/masked_event_drum_sequencer.sv
/*
 * masked event drum sequencer: sixteen steps advanced by time, event or jog,
 * output pattern anded with a per-step mask, discrete or word output.
 * assumes start, jog, drum reset and events arrive asynchronously from the
 * controlling program and that software uses the plain strobe register port.
 */
// The strobed register port and the register offsets were chosen for this implementation.

// Functional notes
// R1: sixteen steps, sixteen outputs; each step has counts, event and pattern.
// R2: final outputs are current pattern anded bitwise with that step's mask.
// R3: sixteen consecutive mask words, one per step, from a base location.
// R4: each rising jog edge advances the step regardless of the timer.
// R5: time-based progress only while start is asserted.
// R6: counting pauses while the current step's event is false.
// R7: step advances when count equals counts per step, 0 to 9999.
// R8: sequencing halts after the last step and while reset is asserted.
// R9: preset step 1 to 16 loads on reset and on program-to-run.
// R10: timebase 0 to 99.99 s per count in 0.01 s units.
// R11: four status counters: count, timer, preset, current step; base 0 to 174.
// R12: preset counter writable any time; other three counters read-only.
// R13: drum-complete flag sets on last step done, clears on reset.
// R14: word variant writes masked result as one word to a configured destination.
// R15: a step with no event assigned is purely time based.
// R16: mask changes apply to outputs at once without a restart.
// R17: program should load zero masks on first scan to keep outputs off.
// R18: program must initialise one mask word per step in use.
// R19: each output pattern is a 16-bit value, one bit per output.
// R20: any step change clears count within step and timer value.
// R21: current-step counter shows active step; count counter shows its counts.
module masked_event_drum_sequencer #(
	parameter int TICK_CYCLES = drum_pkg::TICK_CYCLES
) (
	// clock and reset
	input wire logic clock_in,
	input wire logic rst_in,
	// controlling program inputs
	input wire logic start_in,
	input wire logic jog_in,
	input wire logic drum_reset_in,
	input wire logic [15:0] events_in,
	// register port
	input wire logic [7:0] addr_in,
	input wire logic [15:0] wdata_in,
	input wire logic wr_in,
	input wire logic rd_in,
	output logic [15:0] rdata_out,
	// drum outputs
	output logic [15:0] discrete_out,
	output logic [15:0] word_out,
	output logic [15:0] word_dest_out,
	output logic drum_complete_flag_out
);

	typedef struct packed {
		logic [18:0] sync1;
		logic [18:0] sync2;
		logic jog_q;
		logic run_q;
		logic run_mode;
		logic word_mode;
		logic [15:0] timebase;
		logic [7:0] ctr_base;
		logic [15:0] ev_assign;
		logic [15:0] word_dest;
		logic [4:0] preset;
		logic [4:0] cur_step;
		logic [15:0] step_count;
		logic [15:0] timer_value;
		logic complete;
		logic [20:0] tick_cnt;
		logic [15:0] disc;
		logic [15:0] word;
		logic [15:0] rdata;
		logic rd_mem;
	} state_t;

	state_t st;
	state_t next_st;

	logic start_s;
	logic jog_s;
	logic rst_s;
	logic [15:0] ev_s;
	logic [3:0] idx;
	logic jog_rise;
	logic mode_rise;
	logic active;
	logic ev_ok;
	logic counting;
	logic reached;
	logic adv_time;
	logic advance;
	logic tick;
	logic tb_write;
	drum_pkg::field_t bus_field;
	logic mem_wr;
	logic [15:0] mem_rdata;
	drum_pkg::step_entry_t entry;
	logic [15:0] masked;

	// ****************************************
	// derived conditions
	// ****************************************
	// the synchroniser's second stage is the only stage any logic reads
	assign start_s = st.sync2[0];
	assign jog_s = st.sync2[1];
	assign rst_s = st.sync2[2];
	assign ev_s = st.sync2[18:3];
	assign idx = 4'(st.cur_step - drum_pkg::FIRST_STEP);
	assign jog_rise = jog_s && !st.jog_q;
	assign mode_rise = st.run_mode && !st.run_q;
	assign active = st.run_mode && !st.complete && !rst_s; // [R8]
	assign ev_ok = !st.ev_assign[idx] || ev_s[idx]; // [R6] [R15]
	assign counting = active && start_s && ev_ok; // [R5]
	assign reached = st.step_count == entry.counts;
	assign adv_time = counting && reached; // [R7]
	assign advance = adv_time || (active && jog_rise); // [R4]
	assign tick = st.tick_cnt == 21'(TICK_CYCLES - 1);
	assign masked = entry.pattern & entry.mask; // [R2] [R16] [R19]

	// table window sits at 0x10..0x3f, field taken from address bits [5:4]
	assign bus_field = (addr_in[7:6] == 2'b00) ? drum_pkg::field_t'(addr_in[5:4])
		: drum_pkg::FIELD_NONE;
	assign mem_wr = wr_in && bus_field != drum_pkg::FIELD_NONE
		&& !(bus_field == drum_pkg::FIELD_COUNTS && wdata_in > drum_pkg::MAX_COUNTS);
	assign tb_write = wr_in && addr_in == drum_pkg::TIMEBASE_OFS
		&& wdata_in <= drum_pkg::MAX_TIMEBASE;

	// ****************************************
	// per-step table
	// ****************************************
	// read port follows the next step so the entry matches cur_step each cycle
	drum_step_table u_table (
		.clock_in(clock_in),
		.rst_in(rst_in),
		.wr_en_in(mem_wr),
		.field_in(bus_field),
		.index_in(addr_in[3:0]),
		.wr_data_in(wdata_in),
		.bus_rdata_out(mem_rdata),
		.step_index_in(4'(next_st.cur_step - drum_pkg::FIRST_STEP)), // [R3]
		.step_entry_out(entry)
	);

	// ****************************************
	// next state
	// ****************************************
	always_comb begin
		next_st = st;
		next_st.sync1 = {events_in, drum_reset_in, jog_in, start_in};
		next_st.sync2 = st.sync1;
		next_st.jog_q = jog_s;
		next_st.run_q = st.run_mode;
		next_st.tick_cnt = tick ? '0 : st.tick_cnt + 21'h000001; // [R10]
		next_st.rdata = '0;
		next_st.rd_mem = rd_in && bus_field != drum_pkg::FIELD_NONE;

		// register writes
		if (wr_in) begin
			unique case (addr_in)
				drum_pkg::CONTROL_OFS: begin
					next_st.run_mode = wdata_in[drum_pkg::RUN_MODE_BIT];
					next_st.word_mode = wdata_in[drum_pkg::WORD_MODE_BIT];
				end
				drum_pkg::CTR_BASE_OFS: begin
					if (wdata_in <= 16'(drum_pkg::MAX_CTR_BASE)) begin
						next_st.ctr_base = wdata_in[7:0]; // [R11]
					end
				end
				drum_pkg::EVENT_ASSIGN_OFS: next_st.ev_assign = wdata_in;
				drum_pkg::WORD_DEST_OFS: next_st.word_dest = wdata_in; // [R14]
				drum_pkg::PRESET_STEP_OFS: begin
					if (wdata_in >= 16'(drum_pkg::FIRST_STEP)
						&& wdata_in <= 16'(drum_pkg::LAST_STEP)) begin
						next_st.preset = wdata_in[4:0]; // [R12]
					end
				end
				default: begin
				end
			endcase
		end
		if (tb_write) begin
			next_st.timebase = wdata_in; // [R10]
		end

		// register reads; the three monitoring counters ignore writes
		if (rd_in) begin
			unique case (addr_in)
				drum_pkg::CONTROL_OFS: begin
					next_st.rdata[drum_pkg::RUN_MODE_BIT] = st.run_mode;
					next_st.rdata[drum_pkg::WORD_MODE_BIT] = st.word_mode;
				end
				drum_pkg::TIMEBASE_OFS: next_st.rdata = st.timebase;
				drum_pkg::CTR_BASE_OFS: next_st.rdata = 16'(st.ctr_base);
				drum_pkg::EVENT_ASSIGN_OFS: next_st.rdata = st.ev_assign;
				drum_pkg::FLAGS_OFS: next_st.rdata[drum_pkg::COMPLETE_BIT] = st.complete;
				drum_pkg::WORD_DEST_OFS: next_st.rdata = st.word_dest;
				drum_pkg::STEP_COUNT_OFS: next_st.rdata = st.step_count; // [R11] [R21]
				drum_pkg::TIMER_VALUE_OFS: next_st.rdata = st.timer_value; // [R11]
				drum_pkg::PRESET_STEP_OFS: next_st.rdata = 16'(st.preset); // [R11]
				drum_pkg::CURRENT_STEP_OFS: next_st.rdata = 16'(st.cur_step); // [R21]
				default: next_st.rdata = '0;
			endcase
		end

		// sequencing
		if (rst_s || mode_rise) begin
			next_st.cur_step = st.preset; // [R9]
			next_st.step_count = '0;
			next_st.timer_value = '0;
			next_st.complete = 1'b0; // [R13]
		end else if (advance) begin
			next_st.step_count = '0; // [R20]
			next_st.timer_value = '0; // [R20]
			if (st.cur_step == drum_pkg::LAST_STEP) begin
				next_st.complete = 1'b1; // [R13] [R8]
			end else begin
				next_st.cur_step = st.cur_step + 5'h01; // [R1]
			end
		end else if (counting && tick) begin
			// a timebase of zero or one both give one count per 0.01 s tick
			if (st.timer_value + 16'h0001 >= st.timebase) begin
				next_st.step_count = st.step_count + 16'h0001; // [R21]
				next_st.timer_value = '0;
			end else begin
				next_st.timer_value = st.timer_value + 16'h0001;
			end
		end

		// outputs, one register stage after the table read
		next_st.disc = st.word_mode ? '0 : masked; // [R2]
		next_st.word = st.word_mode ? masked : '0; // [R14]
	end

	// ****************************************
	// state register
	// ****************************************
	always_ff @(posedge clock_in) begin
		if (rst_in) begin
			st <= '0;
			st.timebase <= drum_pkg::TIMEBASE_RESET;
			st.ctr_base <= drum_pkg::CTR_BASE_RESET;
			st.preset <= drum_pkg::PRESET_RESET;
			st.cur_step <= drum_pkg::PRESET_RESET;
		end else begin
			st <= next_st;
		end
	end

	assign rdata_out = st.rd_mem ? mem_rdata : st.rdata;
	assign discrete_out = st.disc;
	assign word_out = st.word;
	assign word_dest_out = st.word_dest;
	assign drum_complete_flag_out = st.complete;

	// ****************************************
	// checks
	// ****************************************
	a_jog_step_advance: assert property (@(posedge clock_in) disable iff (rst_in) // [R4]
		(active && jog_rise && !mode_rise && st.cur_step < drum_pkg::LAST_STEP)
		|=> st.cur_step == $past(st.cur_step) + 5'h01)
		else $error("jog edge did not advance the step");

	a_start_gates_time: assert property (@(posedge clock_in) disable iff (rst_in) // [R5]
		(!start_s && !jog_rise && !rst_s && !mode_rise)
		|=> $stable(st.step_count) && $stable(st.cur_step))
		else $error("step progressed without start");

	a_event_pauses_count: assert property (@(posedge clock_in) disable iff (rst_in) // [R6]
		(!ev_ok && !jog_rise && !rst_s && !mode_rise) |=> $stable(st.step_count))
		else $error("count moved while event false");

	a_count_reach_moves: assert property (@(posedge clock_in) disable iff (rst_in) // [R7]
		(adv_time && !rst_s && !mode_rise)
		|=> (st.cur_step != $past(st.cur_step)) || st.complete)
		else $error("reached count did not advance");

	a_done_holds_step: assert property (@(posedge clock_in) disable iff (rst_in) // [R8]
		(st.complete && !rst_s && !mode_rise) |=> $stable(st.cur_step) && st.complete)
		else $error("drum moved after completion");

	a_reset_loads_preset: assert property (@(posedge clock_in) disable iff (rst_in) // [R9]
		rst_s |=> st.cur_step == $past(st.preset) && !st.complete && st.step_count == 16'h0000)
		else $error("drum reset did not load preset");

	a_step_change_clears: assert property (@(posedge clock_in) disable iff (rst_in) // [R20]
		!$stable(st.cur_step) |-> st.step_count == 16'h0000 && st.timer_value == 16'h0000)
		else $error("counters not cleared on step change");

	a_mask_and_output: assert property (@(posedge clock_in) disable iff (rst_in) // [R2]
		##1 (discrete_out | word_out) == $past(entry.pattern & entry.mask))
		else $error("output is not pattern and mask");

	a_step_in_range: assert property (@(posedge clock_in) disable iff (rst_in) // [R21]
		st.cur_step >= drum_pkg::FIRST_STEP && st.cur_step <= drum_pkg::LAST_STEP)
		else $error("current step out of range");

	a_idle_holds_step: assert property (@(posedge clock_in) disable iff (rst_in) // [R8]
		(!st.run_mode && !rst_s)
		|=> $stable(st.cur_step) && $stable(st.step_count))
		else $error("drum moved in program mode");

	a_only_on_tick: assert property (@(posedge clock_in) disable iff (rst_in) // [R10]
		(!tick && !advance && !rst_s && !mode_rise)
		|=> $stable(st.step_count) && $stable(st.timer_value))
		else $error("count moved between timebase ticks");

	a_timer_counts_up: assert property (@(posedge clock_in) disable iff (rst_in) // [R10]
		(counting && tick && !advance && !mode_rise
			&& st.timer_value + 16'h0001 < st.timebase)
		|=> st.timer_value == $past(st.timer_value) + 16'h0001 && $stable(st.step_count))
		else $error("timer value did not count the tick");

	a_timer_rollover: assert property (@(posedge clock_in) disable iff (rst_in) // [R10]
		(counting && tick && !advance && !mode_rise
			&& st.timer_value + 16'h0001 >= st.timebase)
		|=> st.timer_value == 16'h0000
			&& st.step_count == $past(st.step_count) + 16'h0001)
		else $error("timebase period did not add a count");

	a_last_sets_done: assert property (@(posedge clock_in) disable iff (rst_in) // [R13]
		(advance && st.cur_step == drum_pkg::LAST_STEP && !mode_rise)
		|=> st.complete && $stable(st.cur_step))
		else $error("last step did not set drum complete");

	a_run_edge_loads: assert property (@(posedge clock_in) disable iff (rst_in) // [R9]
		mode_rise |=> st.cur_step == $past(st.preset) && !st.complete
			&& st.step_count == 16'h0000 && st.timer_value == 16'h0000)
		else $error("run edge did not load preset");

	a_preset_write: assert property (@(posedge clock_in) disable iff (rst_in) // [R12]
		(wr_in && addr_in == drum_pkg::PRESET_STEP_OFS
			&& wdata_in >= 16'(drum_pkg::FIRST_STEP) && wdata_in <= 16'(drum_pkg::LAST_STEP))
		|=> st.preset == $past(wdata_in[4:0]))
		else $error("preset step write was lost");

	a_preset_in_range: assert property (@(posedge clock_in) disable iff (rst_in) // [R9]
		st.preset >= drum_pkg::FIRST_STEP && st.preset <= drum_pkg::LAST_STEP)
		else $error("preset step out of range");

	a_word_mode_out: assert property (@(posedge clock_in) disable iff (rst_in) // [R14]
		st.word_mode |=> discrete_out == 16'h0000 && word_out == $past(masked))
		else $error("word mode output wrong");

	a_discrete_mode_out: assert property (@(posedge clock_in) disable iff (rst_in) // [R2]
		!st.word_mode |=> word_out == 16'h0000 && discrete_out == $past(masked))
		else $error("discrete mode output wrong");

endmodule

// ===== test/drum_program_model.sv
/*
 * controlling program model: start level, jog and drum reset pulses, event contacts.
 * assumes one-clock requests from the bench and two sync flops inside the drum.
 */
module drum_program_model (
	// clock and reset
	input wire logic clock_in,
	input wire logic rst_in,
	// bench requests
	input wire logic start_req_in,
	input wire logic jog_req_in,
	input wire logic reset_req_in,
	input wire logic [15:0] events_req_in,
	// drum inputs
	output logic start_out,
	output logic jog_out,
	output logic drum_reset_out,
	output logic [15:0] events_out
);
	timeunit 1ns;
	timeprecision 1ps;
	// pulses last four clocks so the sync flops never miss an edge
	logic [2:0] jog_left = 3'h0;
	logic [2:0] rst_left = 3'h0;

	always @(posedge clock_in) begin
		jog_left <= jog_req_in ? 3'h4 : jog_left - 3'(jog_left != 3'h0);
		rst_left <= reset_req_in ? 3'h4 : rst_left - 3'(rst_left != 3'h0);
		start_out <= start_req_in & ~rst_in;
		events_out <= events_req_in;
		jog_out <= jog_left != 3'h0;
		drum_reset_out <= rst_left != 3'h0;
	end
endmodule

// ===== test/tb_masked_event_drum_sequencer.sv
/*
 * self-checking bench of the masked event drum sequencer.
 * assumes a fast tick of four clocks and the plain strobe register port.
 */
module tb_masked_event_drum_sequencer;
	timeunit 1ns;
	timeprecision 1ps;
	logic clock_in = 1'b0;
	logic rst_in = 1'b1;
	logic start_req = 1'b0;
	logic jog_req = 1'b0;
	logic reset_req = 1'b0;
	logic [15:0] events_req = 16'h0000;
	logic start, jog, drum_reset, flag;
	logic [15:0] events, rdata, discrete, word, word_dest;
	logic [7:0] addr = 8'h00;
	logic [15:0] wdata = 16'h0000;
	logic wr = 1'b0;
	logic rd = 1'b0;
	int n_mismatch = 0;
	int total_checks = 0;
	integer seed = 32'h79e02650;
	logic [15:0] mask_m [16];
	logic [15:0] pat_m [16];
	logic [15:0] v;
	// address and value after reset
	localparam logic [23:0] RTAB [8] = '{24'h010001, 24'h020000, 24'h0a0001,
		24'h0b0001, 24'h080000, 24'h090000, 24'h070000, 24'h040000};
	// address, value written, value read back
	localparam logic [39:0] WTAB [10] = '{40'h0a00000001, 40'h0a00110001,
		40'h0a00100010, 40'h0127100001, 40'h01270f270f, 40'h0200af0000,
		40'h0200ae00ae, 40'h0b00050001, 40'h0800050000, 40'h0712340000};

	drum_program_model u_prog (.clock_in(clock_in), .rst_in(rst_in),
		.start_req_in(start_req), .jog_req_in(jog_req), .reset_req_in(reset_req),
		.events_req_in(events_req), .start_out(start), .jog_out(jog),
		.drum_reset_out(drum_reset), .events_out(events));
	masked_event_drum_sequencer #(.TICK_CYCLES(4)) u_dut (.clock_in(clock_in),
		.rst_in(rst_in), .start_in(start), .jog_in(jog), .drum_reset_in(drum_reset),
		.events_in(events), .addr_in(addr), .wdata_in(wdata), .wr_in(wr), .rd_in(rd),
		.rdata_out(rdata), .discrete_out(discrete), .word_out(word),
		.word_dest_out(word_dest), .drum_complete_flag_out(flag));

	initial begin
		forever #4 clock_in = ~clock_in;
	end

	// ****************************************
	// helpers
	// ****************************************
	function automatic logic [15:0] final_out(input int s);
		return pat_m[s - 1] & mask_m[s - 1];
	endfunction
	task automatic chk(input logic [15:0] seen, input logic [15:0] expected);
		total_checks++;
		if (seen !== expected) begin
			n_mismatch++;
			$display("wrong value at %0t: seen %h expected %h", $time, seen, expected);
		end
	endtask
	task automatic wr_reg(input logic [7:0] a, input logic [15:0] d);
		@(posedge clock_in);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clock_in);
		wr <= 1'b0;
	endtask
	task automatic rd_reg(input logic [7:0] a);
		@(posedge clock_in);
		addr <= a;
		rd <= 1'b1;
		@(posedge clock_in);
		rd <= 1'b0;
		@(negedge clock_in);
		v = rdata;
	endtask
	task automatic rd_chk(input logic [7:0] a, input logic [15:0] e);
		rd_reg(a);
		chk(v, e);
	endtask
	task automatic settle(input int n);
		repeat (n) @(posedge clock_in);
		@(negedge clock_in);
	endtask
	task automatic pulse(input bit is_jog);
		@(posedge clock_in);
		jog_req <= is_jog;
		reset_req <= ~is_jog;
		@(posedge clock_in);
		jog_req <= 1'b0;
		reset_req <= 1'b0;
		settle(10);
	endtask
	task automatic wait_leave(input logic [15:0] s);
		v = s;
		for (int i = 0; i < 100 && v === s; i++)
			rd_reg(8'h0b);
		if (v === s) n_mismatch++;
	endtask
	task automatic wait_done();
		for (int i = 0; i < 3000 && flag !== 1'b1; i++)
			@(posedge clock_in);
		if (flag !== 1'b1) n_mismatch++;
		settle(20);
	endtask
	task automatic end_of_test();
		$display("checks %0d mismatches %0d", total_checks, n_mismatch);
		if (n_mismatch == 0 && total_checks > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask

	// ****************************************
	// scenarios
	// ****************************************
	initial begin
		repeat (20000) @(posedge clock_in);
		n_mismatch++;
		end_of_test();
	end

	initial begin
		repeat (3) @(posedge clock_in);
		rst_in <= 1'b0;
		settle(0);
		chk(discrete, 16'h0000);
		foreach (RTAB[i]) rd_chk(RTAB[i][23:16], RTAB[i][15:0]);
		foreach (WTAB[i]) begin
			wr_reg(WTAB[i][39:32], WTAB[i][31:16]);
			rd_chk(WTAB[i][39:32], WTAB[i][15:0]);
		end
		wr_reg(8'h01, 16'h0002);
		for (int s = 0; s < 16; s++) begin
			mask_m[s] = 16'($random(seed));
			pat_m[s] = 16'($random(seed));
			wr_reg(8'h10 + 8'(s), mask_m[s]);
			wr_reg(8'h20 + 8'(s), pat_m[s]);
			wr_reg(8'h30 + 8'(s), (s > 4 && s < 8) ? 16'h0002 : 16'h0000);
		end
		rd_chk(8'h1c, mask_m[12]);
		wr_reg(8'h03, 16'h0040);
		events_req <= 16'hffff;
		start_req <= 1'b1;
		wr_reg(8'h00, 16'h0001);
		wait_done();
		rd_chk(8'h0b, 16'h0010);
		rd_chk(8'h04, 16'h0001);
		chk(discrete, final_out(16));
		pulse(1'b1);
		rd_chk(8'h0b, 16'h0010);
		start_req <= 1'b0;
		events_req <= 16'h0000;
		wr_reg(8'h0a, 16'h0005);
		pulse(1'b0);
		rd_chk(8'h0b, 16'h0005);
		chk({15'h0000, flag}, 16'h0000);
		chk(discrete, final_out(5));
		mask_m[4] = 16'($random(seed));
		wr_reg(8'h14, mask_m[4]);
		settle(4);
		chk(discrete, final_out(5));
		wr_reg(8'h00, 16'h0003);
		wr_reg(8'h05, mask_m[0]);
		settle(4);
		chk(word, final_out(5));
		chk(discrete, 16'h0000);
		chk(word_dest, mask_m[0]);
		wr_reg(8'h00, 16'h0001);
		settle(40);
		rd_chk(8'h0b, 16'h0005);
		pulse(1'b1);
		rd_chk(8'h0b, 16'h0006);
		rd_chk(8'h08, 16'h0000);
		start_req <= 1'b1;
		settle(2);
		rd_chk(8'h0b, 16'h0006);
		wait_leave(16'h0006);
		chk(v, 16'h0007);
		rd_chk(8'h09, 16'h0000);
		settle(40);
		rd_chk(8'h0b, 16'h0007);
		rd_chk(8'h08, 16'h0000);
		events_req <= 16'h0040;
		wait_leave(16'h0007);
		chk(v, 16'h0008);
		wait_done();
		start_req <= 1'b0;
		wr_reg(8'h00, 16'h0000);
		wr_reg(8'h00, 16'h0001);
		settle(4);
		rd_chk(8'h0b, 16'h0005);
		chk({15'h0000, flag}, 16'h0000);
		end_of_test();
	end
endmodule
